// [core/pmic_ctrl.sv]
// Power-down, input monitor and interrupt enable control registers with sticky status.
//
// Notes on behaviour
// - Per-input disable bit, zero keeps input enabled.
// - Lock mode selects unlock release: lock, or lock+stable.
// - Doubler bypass zero doubles crystal, one passes through.
// - Output disable bit shuts output, driver goes high-Z.
// - Digital loop disable bit stops the loop.
// - Modulator disable bit turns the modulator off.
// - Calibration hold bit keeps calibration disabled.
// - Per-input 17-bit missing-edge limit, resets to all ones.
// - Unlock enable passes unlock sticky flag to interrupt.
// - Holdover enable passes holdover sticky flag to interrupt.
// - Per-input enable passes missing-reference flag to interrupt.
// - Flags with enable zero never affect interrupt.
// - Status flags are sticky, cleared by writing one.
`timescale 1ns/100ps
`include "pmic_defines.svh"

module pmic_ctrl
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire pmic_pkg::pmic_addr_type reg_addr,
   input  wire pmic_pkg::pmic_data_type reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output pmic_pkg::pmic_data_type      reg_rdata,
   output logic                         reg_rvalid,
   input  wire logic                    pll_locked,
   input  wire logic                    outputs_stable,
   input  wire logic                    holdover_alarm,
   input  wire logic [1:0]              ref_missing_alarm,
   output logic [1:0]                   ref_input_off,
   output logic                         lock_release_select,
   output logic                         unlock_alarm,
   output logic                         xtal_doubler_bypass,
   output logic                         xtal_ref_doubled,
   output logic [2:0]                   output_off,
   output logic [2:0]                   output_drive_en,
   output logic                         digital_loop_off,
   output logic                         modulator_off,
   output logic                         calibration_hold,
   output pmic_pkg::pmic_limit_type     missing_ref_period_limit0,
   output pmic_pkg::pmic_limit_type     missing_ref_period_limit1,
   output logic                         irq_out_n
);
   import pmic_pkg::*;

   // ----------------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------------

   // Shared by the write and the read paths so that both agree on the map.
   function automatic pmic_sel_type decode(input pmic_addr_type a);
      pmic_sel_type s;
      s = PMIC_SEL_NONE;
      unique case (a)
         `PMIC_OFS_REF_DISABLE:     s = PMIC_SEL_REF;
         `PMIC_OFS_LOCK_DOUBLER:    s = PMIC_SEL_LOCK;
         `PMIC_OFS_OUTPUT_DISABLE:  s = PMIC_SEL_OUT;
         `PMIC_OFS_LOOP_DISABLE:    s = PMIC_SEL_LOOP;
         `PMIC_OFS_LIMIT0_HIGH:     s = PMIC_SEL_L0_HIGH;
         `PMIC_OFS_LIMIT0_MID:      s = PMIC_SEL_L0_MID;
         `PMIC_OFS_LIMIT0_LOW:      s = PMIC_SEL_L0_LOW;
         `PMIC_OFS_LIMIT1_HIGH:     s = PMIC_SEL_L1_HIGH;
         `PMIC_OFS_LIMIT1_MID:      s = PMIC_SEL_L1_MID;
         `PMIC_OFS_LIMIT1_LOW:      s = PMIC_SEL_L1_LOW;
         `PMIC_OFS_RESERVED_A:      s = PMIC_SEL_RSVD;
         `PMIC_OFS_RESERVED_B:      s = PMIC_SEL_RSVD;
         `PMIC_OFS_STICKY_RESERVED: s = PMIC_SEL_RSVD;
         `PMIC_OFS_IRQ_ENABLE:      s = PMIC_SEL_IRQ_EN;
         `PMIC_OFS_STICKY_STATUS:   s = PMIC_SEL_STATUS;
         default:                   s = PMIC_SEL_NONE;
      endcase
      return s;
   endfunction

   pmic_sel_type wr_sel;
   pmic_sel_type rd_sel;

   // Write decode is qualified by the strobe so an idle bus selects nothing; read decode is not.
   assign wr_sel = reg_wr ? decode(reg_addr) : PMIC_SEL_NONE;
   assign rd_sel = decode(reg_addr);

   // ----------------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------------

   logic [1:0]                ref_off_r;
   logic                      lock_sel_r;
   logic                      dbl_byp_r;
   logic [2:0]                out_off_r;
   logic                      dloop_off_r;
   logic                      mod_off_r;
   logic                      cal_hold_r;
   logic [`PMIC_LIMIT_W-1:0]  limit0_r;
   logic [`PMIC_LIMIT_W-1:0]  limit1_r;
   logic [`PMIC_EVT_W-1:0]    irq_en_r;

   // Input reference disables; reserved positions are dropped on write.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ref_off_r <= {2{`PMIC_RST_CONTROL}};
      else if (wr_sel == PMIC_SEL_REF)
         ref_off_r <= {reg_wdata[`PMIC_BIT_REF1_OFF], reg_wdata[`PMIC_BIT_REF0_OFF]};
   end

   // Unlock release mode and crystal doubler bypass.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock_sel_r <= `PMIC_RST_CONTROL;
         dbl_byp_r  <= `PMIC_RST_CONTROL;
      end
      else if (wr_sel == PMIC_SEL_LOCK)
      begin
         lock_sel_r <= reg_wdata[`PMIC_BIT_LOCK_SELECT];
         dbl_byp_r  <= reg_wdata[`PMIC_BIT_DOUBLER_BYPASS];
      end
   end

   // Output disables for the three output pairs.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         out_off_r <= {3{`PMIC_RST_CONTROL}};
      else if (wr_sel == PMIC_SEL_OUT)
         out_off_r <= {reg_wdata[`PMIC_BIT_OUTPUT2_OFF],
                       reg_wdata[`PMIC_BIT_OUTPUT1_OFF],
                       reg_wdata[`PMIC_BIT_OUTPUT0_OFF]};
   end

   // Digital loop, modulator and calibration controls.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dloop_off_r <= `PMIC_RST_CONTROL;
         mod_off_r   <= `PMIC_RST_CONTROL;
         cal_hold_r  <= `PMIC_RST_CONTROL;
      end
      else if (wr_sel == PMIC_SEL_LOOP)
      begin
         dloop_off_r <= reg_wdata[`PMIC_BIT_DLOOP_OFF];
         mod_off_r   <= reg_wdata[`PMIC_BIT_MOD_OFF];
         cal_hold_r  <= reg_wdata[`PMIC_BIT_CAL_HOLD];
      end
   end

   // Missing-reference limits; each byte of the 17-bit value is written on its own.
   // The limit takes effect byte by byte, so a monitor may briefly see a mixed value.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         limit0_r <= `PMIC_RST_LIMIT;
         limit1_r <= `PMIC_RST_LIMIT;
      end
      else
      begin
         unique case (wr_sel)
            PMIC_SEL_L0_HIGH: limit0_r[16]   <= reg_wdata[`PMIC_BIT_LIMIT_TOP];
            PMIC_SEL_L0_MID:  limit0_r[15:8] <= reg_wdata;
            PMIC_SEL_L0_LOW:  limit0_r[7:0]  <= reg_wdata;
            PMIC_SEL_L1_HIGH: limit1_r[16]   <= reg_wdata[`PMIC_BIT_LIMIT_TOP];
            PMIC_SEL_L1_MID:  limit1_r[15:8] <= reg_wdata;
            PMIC_SEL_L1_LOW:  limit1_r[7:0]  <= reg_wdata;
            default:          limit0_r       <= limit0_r;
         endcase
      end
   end

   // Interrupt enables, ordered unlock, holdover, reference 1, reference 0.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_en_r <= {`PMIC_EVT_W{`PMIC_RST_CONTROL}};
      else if (wr_sel == PMIC_SEL_IRQ_EN)
         irq_en_r <= {reg_wdata[`PMIC_BIT_UNLOCK_EVT], reg_wdata[`PMIC_BIT_HOLD_EVT],
                      reg_wdata[`PMIC_BIT_REF1_EVT], reg_wdata[`PMIC_BIT_REF0_EVT]};
   end

   // ----------------------------------------------------------------------------
   // Alarms, sticky status and interrupt
   // ----------------------------------------------------------------------------

   logic [`PMIC_EVT_W-1:0] evt_set;
   logic [`PMIC_EVT_W-1:0] evt_clr;
   logic [`PMIC_EVT_W-1:0] sticky;
   logic                   irq_n_r;

   pmic_lock_release u_lock_release
   (
      .clk            (clk),
      .rst_n          (rst_n),
      .release_select (lock_sel_r),
      .pll_locked     (pll_locked),
      .outputs_stable (outputs_stable),
      .unlock_alarm   (unlock_alarm)
   );

   // Alarm levels set their flags every cycle they are present.
   assign evt_set = {unlock_alarm, holdover_alarm, ref_missing_alarm};
   assign evt_clr = (wr_sel == PMIC_SEL_STATUS) ?
                    {reg_wdata[`PMIC_BIT_UNLOCK_EVT], reg_wdata[`PMIC_BIT_HOLD_EVT],
                     reg_wdata[`PMIC_BIT_REF1_EVT], reg_wdata[`PMIC_BIT_REF0_EVT]} : '0;

   pmic_sticky_flags #(.W(`PMIC_EVT_W)) u_sticky
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .set_evt  (evt_set),
      .clr_mask (evt_clr),
      .flags    (sticky)
   );

   // Registered so the pin never glitches on a decode race.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_n_r <= 1'b1;
      else
         irq_n_r <= ~|(sticky & irq_en_r);
   end

   // ----------------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------------

   pmic_data_type rd_mux;
   pmic_data_type rdata_r;
   logic          rvalid_r;

   // Reserved and unmapped positions read as zero.
   always_comb
   begin
      rd_mux = 8'h00;
      unique case (rd_sel)
         PMIC_SEL_REF:
         begin
            rd_mux[`PMIC_BIT_REF1_OFF] = ref_off_r[1];
            rd_mux[`PMIC_BIT_REF0_OFF] = ref_off_r[0];
         end
         PMIC_SEL_LOCK:
         begin
            rd_mux[`PMIC_BIT_LOCK_SELECT]   = lock_sel_r;
            rd_mux[`PMIC_BIT_DOUBLER_BYPASS] = dbl_byp_r;
         end
         PMIC_SEL_OUT:
         begin
            rd_mux[`PMIC_BIT_OUTPUT2_OFF] = out_off_r[2];
            rd_mux[`PMIC_BIT_OUTPUT1_OFF] = out_off_r[1];
            rd_mux[`PMIC_BIT_OUTPUT0_OFF] = out_off_r[0];
         end
         PMIC_SEL_LOOP:
         begin
            rd_mux[`PMIC_BIT_DLOOP_OFF] = dloop_off_r;
            rd_mux[`PMIC_BIT_MOD_OFF]   = mod_off_r;
            rd_mux[`PMIC_BIT_CAL_HOLD]  = cal_hold_r;
         end
         PMIC_SEL_L0_HIGH: rd_mux[`PMIC_BIT_LIMIT_TOP] = limit0_r[16];
         PMIC_SEL_L0_MID:  rd_mux = limit0_r[15:8];
         PMIC_SEL_L0_LOW:  rd_mux = limit0_r[7:0];
         PMIC_SEL_L1_HIGH: rd_mux[`PMIC_BIT_LIMIT_TOP] = limit1_r[16];
         PMIC_SEL_L1_MID:  rd_mux = limit1_r[15:8];
         PMIC_SEL_L1_LOW:  rd_mux = limit1_r[7:0];
         PMIC_SEL_IRQ_EN:
         begin
            rd_mux[`PMIC_BIT_UNLOCK_EVT] = irq_en_r[3];
            rd_mux[`PMIC_BIT_HOLD_EVT]   = irq_en_r[2];
            rd_mux[`PMIC_BIT_REF1_EVT]   = irq_en_r[1];
            rd_mux[`PMIC_BIT_REF0_EVT]   = irq_en_r[0];
         end
         PMIC_SEL_STATUS:
         begin
            rd_mux[`PMIC_BIT_UNLOCK_EVT] = sticky[3];
            rd_mux[`PMIC_BIT_HOLD_EVT]   = sticky[2];
            rd_mux[`PMIC_BIT_REF1_EVT]   = sticky[1];
            rd_mux[`PMIC_BIT_REF0_EVT]   = sticky[0];
         end
         PMIC_SEL_RSVD:    rd_mux = 8'h00;
         PMIC_SEL_NONE:    rd_mux = 8'h00;
      endcase
   end

   // Read data is captured at the edge that samples the strobe and held until the next read.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_r <= 8'h00;
      else if (reg_rd)
         rdata_r <= rd_mux;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rvalid_r <= 1'b0;
      else
         rvalid_r <= reg_rd;
   end

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------

   assign reg_rdata                 = rdata_r;
   assign reg_rvalid                = rvalid_r;
   assign ref_input_off             = ref_off_r;
   assign lock_release_select       = lock_sel_r;
   assign xtal_doubler_bypass       = dbl_byp_r;
   assign xtal_ref_doubled          = ~dbl_byp_r;
   assign output_off                = out_off_r;
   assign output_drive_en           = ~out_off_r;
   assign digital_loop_off          = dloop_off_r;
   assign modulator_off             = mod_off_r;
   assign calibration_hold          = cal_hold_r;
   assign missing_ref_period_limit0 = limit0_r;
   assign missing_ref_period_limit1 = limit1_r;
   assign irq_out_n                 = irq_n_r;

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_REF_OFF_WRITE: assert property
      (reg_wr && reg_addr == `PMIC_OFS_REF_DISABLE |=>
       ref_input_off == {$past(reg_wdata[`PMIC_BIT_REF1_OFF]), $past(reg_wdata[`PMIC_BIT_REF0_OFF])})
      else $error("Reference disable did not follow the write.");

   AST_UNLOCK_FAST: assert property
      (!lock_sel_r && pll_locked |=> !unlock_alarm)
      else $error("Unlock alarm held after lock in fast release mode.");

   AST_UNLOCK_STABLE: assert property
      (lock_sel_r && pll_locked && !outputs_stable |=> unlock_alarm)
      else $error("Unlock alarm released before outputs were stable.");

   AST_DOUBLER_WRITE: assert property
      (reg_wr && reg_addr == `PMIC_OFS_LOCK_DOUBLER |=>
       xtal_ref_doubled == !$past(reg_wdata[`PMIC_BIT_DOUBLER_BYPASS]))
      else $error("Doubler selection did not follow the write.");

   AST_OUTPUT_HIZ: assert property
      (reg_wr && reg_addr == `PMIC_OFS_OUTPUT_DISABLE && reg_wdata[`PMIC_BIT_OUTPUT0_OFF] |=>
       output_off[0] && !output_drive_en[0])
      else $error("Disabled output still driven.");

   AST_LOOP_WRITE: assert property
      (reg_wr && reg_addr == `PMIC_OFS_LOOP_DISABLE |=>
       {digital_loop_off, modulator_off, calibration_hold} ==
       {$past(reg_wdata[`PMIC_BIT_DLOOP_OFF]), $past(reg_wdata[`PMIC_BIT_MOD_OFF]),
        $past(reg_wdata[`PMIC_BIT_CAL_HOLD])})
      else $error("Loop block controls did not follow the write.");

   AST_RSVD_READ: assert property
      (reg_rd && reg_addr == `PMIC_OFS_RESERVED_A |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("Reserved register read nonzero.");

   AST_LIMIT_LOW: assert property
      (reg_wr && reg_addr == `PMIC_OFS_LIMIT0_LOW |=>
       missing_ref_period_limit0[7:0] == $past(reg_wdata) && $stable(missing_ref_period_limit0[16:8]))
      else $error("Limit low byte write misplaced.");

   AST_IRQ_ASSERT: assert property
      (|(sticky & irq_en_r) |=> !irq_out_n)
      else $error("Enabled sticky flag did not raise the interrupt.");

   AST_IRQ_MASKED: assert property
      ((sticky & irq_en_r) == '0 |=> irq_out_n)
      else $error("Masked flag reached the interrupt.");

   AST_STICKY_SET: assert property
      (ref_missing_alarm[0] |=> sticky[0] [*1] ##1 (sticky[0] || evt_clr[0] || $past(evt_clr[0])))
      else $error("Reference 0 flag did not set on its alarm.");

   AST_STICKY_HOLD: assert property
      (sticky[2] && !evt_clr[2] |=> sticky[2])
      else $error("Holdover flag dropped without a clear.");

   COV_IRQ_RAISED: cover property (irq_out_n ##1 !irq_out_n);
   COV_W1C_CLEAR:  cover property (sticky[3] && evt_clr[3] && !unlock_alarm ##1 !sticky[3]);
   COV_STABLE_REL: cover property (lock_sel_r && unlock_alarm ##1 !unlock_alarm);

endmodule

// [core/pmic_defines.svh]
// Offsets, field positions, reset values and widths of the power and monitor control registers.
`ifndef PMIC_DEFINES_SVH
`define PMIC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PMIC_OFS_REF_DISABLE      16'h006d
`define PMIC_OFS_LOCK_DOUBLER     16'h006e
`define PMIC_OFS_OUTPUT_DISABLE   16'h006f
`define PMIC_OFS_LOOP_DISABLE     16'h0070
`define PMIC_OFS_LIMIT0_HIGH      16'h0071
`define PMIC_OFS_LIMIT0_MID       16'h0072
`define PMIC_OFS_LIMIT0_LOW       16'h0073
`define PMIC_OFS_LIMIT1_HIGH      16'h0074
`define PMIC_OFS_LIMIT1_MID       16'h0075
`define PMIC_OFS_LIMIT1_LOW       16'h0076
`define PMIC_OFS_RESERVED_A       16'h0077
`define PMIC_OFS_RESERVED_B       16'h0078
`define PMIC_OFS_IRQ_ENABLE       16'h0079
`define PMIC_OFS_STICKY_STATUS    16'h0200
`define PMIC_OFS_STICKY_RESERVED  16'h0201

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PMIC_BIT_REF0_OFF         4
`define PMIC_BIT_REF1_OFF         5
`define PMIC_BIT_DOUBLER_BYPASS   0
`define PMIC_BIT_LOCK_SELECT      1
`define PMIC_BIT_OUTPUT0_OFF      2
`define PMIC_BIT_OUTPUT1_OFF      3
`define PMIC_BIT_OUTPUT2_OFF      4
`define PMIC_BIT_CAL_HOLD         1
`define PMIC_BIT_MOD_OFF          2
`define PMIC_BIT_DLOOP_OFF        3
`define PMIC_BIT_LIMIT_TOP        0
`define PMIC_BIT_REF0_EVT         0
`define PMIC_BIT_REF1_EVT         1
`define PMIC_BIT_HOLD_EVT         4
`define PMIC_BIT_UNLOCK_EVT       6

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define PMIC_RST_CONTROL          1'b0
`define PMIC_RST_LIMIT            17'h1ffff
`define PMIC_LIMIT_W              17
`define PMIC_EVT_W                4

`endif

// [core/pmic_pkg.sv]
// Types shared by the power and monitor control register block.
package pmic_pkg;

   typedef logic [15:0]              pmic_addr_type;
   typedef logic [7:0]               pmic_data_type;
   typedef logic [16:0]              pmic_limit_type;

   // Register selected by an address; PMIC_SEL_NONE covers every unmapped address.
   typedef enum logic [3:0]
   {
      PMIC_SEL_NONE    = 4'b0000,
      PMIC_SEL_REF     = 4'b0001,
      PMIC_SEL_LOCK    = 4'b0010,
      PMIC_SEL_OUT     = 4'b0011,
      PMIC_SEL_LOOP    = 4'b0100,
      PMIC_SEL_L0_HIGH = 4'b0101,
      PMIC_SEL_L0_MID  = 4'b0110,
      PMIC_SEL_L0_LOW  = 4'b0111,
      PMIC_SEL_L1_HIGH = 4'b1000,
      PMIC_SEL_L1_MID  = 4'b1001,
      PMIC_SEL_L1_LOW  = 4'b1010,
      PMIC_SEL_RSVD    = 4'b1011,
      PMIC_SEL_IRQ_EN  = 4'b1100,
      PMIC_SEL_STATUS  = 4'b1101
   } pmic_sel_type;

endpackage

// [core/pmic_sticky_flags.sv]
// Sticky event flags, set by hardware and cleared by writing one.
`timescale 1ns/100ps

module pmic_sticky_flags
#(
   parameter int W = 4
)
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic [W-1:0]  set_evt,
   input  wire logic [W-1:0]  clr_mask,
   output logic [W-1:0]       flags
);

   logic [W-1:0] flags_r;

   // A set in the same cycle as its clear wins, so no event is ever lost.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flags_r <= '0;
      else
         flags_r <= (flags_r & ~clr_mask) | set_evt;
   end

   assign flags = flags_r;

endmodule

// [core/pmic_lock_release.sv]
// Loss-of-lock alarm qualifier with selectable release condition.
`timescale 1ns/100ps

module pmic_lock_release
(
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  release_select,
   input  wire logic  pll_locked,
   input  wire logic  outputs_stable,
   output logic       unlock_alarm
);

   logic unlock_r;

   // Starts in alarm: the loop is not known to be locked coming out of reset.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         unlock_r <= 1'b1;
      else if (release_select)
         unlock_r <= ~(pll_locked & outputs_stable);
      else
         unlock_r <= ~pll_locked;
   end

   assign unlock_alarm = unlock_r;

endmodule

// [tb/pmic_tb.sv]
// Self-checking testbench for the power and monitor control register block.
`timescale 1ns/100ps

module tb;
   import pmic_pkg::*;

   // ----------------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------------
   logic                  clk, rst_n, reg_wr, reg_rd, reg_rvalid, pll_locked, outputs_stable, holdover_alarm;
   pmic_addr_type         reg_addr;
   pmic_data_type         reg_wdata, reg_rdata;
   logic [1:0]            ref_missing_alarm, ref_input_off;
   logic                  lock_release_select, unlock_alarm, xtal_doubler_bypass, xtal_ref_doubled;
   logic [2:0]            output_off, output_drive_en;
   logic                  digital_loop_off, modulator_off, calibration_hold, irq_out_n;
   pmic_limit_type        missing_ref_period_limit0, missing_ref_period_limit1;
   logic [31:0]           exp_q[$];
   logic [31:0]           lfsr_r;
   logic [7:0]            sh[12];
   logic [7:0]            msk[12] = '{8'h30, 8'h03, 8'h1c, 8'h0e, 8'h01, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00};
   logic [7:0]            rst_v[13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff,
                                        8'h00, 8'h00, 8'h00};
   int                    b_tab[4] = '{0, 1, 4, 6};
   int                    err_count, checks, cyc, i, p, b;

   pmic_ctrl i_pmic_ctrl (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
      .pll_locked, .outputs_stable, .holdover_alarm, .ref_missing_alarm, .ref_input_off, .lock_release_select,
      .unlock_alarm, .xtal_doubler_bypass, .xtal_ref_doubled, .output_off, .output_drive_en, .digital_loop_off,
      .modulator_off, .calibration_hold, .missing_ref_period_limit0, .missing_ref_period_limit1, .irq_out_n);

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   function automatic logic [31:0] lfsr_nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Requests start 2 ns after an edge; every task sets both strobes, so the two are never high at once.
   task automatic tick(input int n);
      {reg_wr, reg_rd} = 2'b00;
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      {reg_wr, reg_rd} = 2'b10;
      @(posedge clk);
      #2;
   endtask

   // The expectation is queued before the strobe so the monitor always finds it waiting.
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      reg_addr = a;
      {reg_wr, reg_rd} = 2'b01;
      @(posedge clk);
      #2;
   endtask

   // ----------------------------------------------------------------------------
   // Clock, timeout and read monitor
   // ----------------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // A hung run is cut short well past the fewer than two hundred cycles the sequence needs.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         complete_run();
      end
   end

   // Valid data is taken at the edge that ends its one-cycle pulse; an unexpected pulse compares to all ones.
   always @(posedge clk)
   begin
      if (reg_rvalid === 1'b1)
         chk({24'h0, reg_rdata}, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffffffff);
   end

   // ----------------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------------
   initial
   begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, holdover_alarm, ref_missing_alarm} = '0;
      pll_locked = 1'b1;
      outputs_stable = 1'b1;
      lfsr_r = 32'h72f3;
      repeat (10) @(posedge clk);
      #2;
      rst_n = 1'b1;
      tick(1);
      chk(output_drive_en, 3'h7);
      chk(missing_ref_period_limit0, 17'h1ffff);
      chk(missing_ref_period_limit1, 17'h1ffff);
      for (i = 0; i < 13; i++)
         rd(16'(16'h006d + i), rst_v[i]);
      rd(16'h0100, 8'h00);
      rd(16'h0201, 8'h00);
      rd(16'h0200, 8'h40);
      chk(irq_out_n, 1'b1);
      // Random settings; reserved bits written as zero and limits kept at four or more.
      for (p = 0; p < 3; p++)
      begin
         for (i = 0; i < 12; i++)
         begin
            lfsr_r = lfsr_nxt(lfsr_r);
            sh[i] = lfsr_r[7:0] & msk[i];
            if (i == 6 || i == 9)
               sh[i][2] = 1'b1;
            wr(16'(16'h006d + i), sh[i]);
         end
         tick(1);
         chk(ref_input_off, {sh[0][5], sh[0][4]});
         chk({lock_release_select, xtal_doubler_bypass, xtal_ref_doubled}, {sh[1][1:0], ~sh[1][0]});
         chk({output_off, output_drive_en}, {sh[2][4:2], ~sh[2][4:2]});
         chk({digital_loop_off, modulator_off, calibration_hold}, sh[3][3:1]);
         chk(missing_ref_period_limit0, {sh[4][0], sh[5], sh[6]});
         chk(missing_ref_period_limit1, {sh[7][0], sh[8], sh[9]});
         for (i = 0; i < 12; i++)
            rd(16'(16'h006d + i), sh[i]);
      end
      // Release mode one waits for stable clocks, mode zero does not.
      wr(16'h006e, 8'h02);
      outputs_stable = 1'b0;
      tick(2);
      chk(unlock_alarm, 1'b1);
      outputs_stable = 1'b1;
      tick(2);
      chk(unlock_alarm, 1'b0);
      wr(16'h006e, 8'h00);
      outputs_stable = 1'b0;
      tick(2);
      chk(unlock_alarm, 1'b0);
      outputs_stable = 1'b1;
      // One alarm pulse per source, first with only the other sources enabled.
      for (i = 0; i < 4; i++)
      begin
         b = b_tab[i];
         wr(16'h0200, 8'h53);
         wr(16'h0079, 8'h53 & ~(8'h01 << b));
         ref_missing_alarm = (b < 2) ? 2'(1 << b) : 2'b00;
         holdover_alarm = (b == 4);
         pll_locked = (b != 6);
         tick(1);
         {ref_missing_alarm, holdover_alarm, pll_locked} = 4'b0001;
         tick(3);
         chk(irq_out_n, 1'b1);
         rd(16'h0200, 8'h01 << b);
         wr(16'h0079, 8'h01 << b);
         rd(16'h0079, 8'h01 << b);
         chk(irq_out_n, 1'b0);
         wr(16'h0200, 8'h01 << b);
         tick(1);
         chk(irq_out_n, 1'b1);
      end
      tick(3);
      // Every queued read must have been answered by a valid pulse.
      chk(exp_q.size(), 0);
      complete_run();
   end
endmodule
